// [rtl/adcsr_pkg.sv]
// Purpose: shared constants for the converter result readout block
// Assumes: 16-bit result and configuration words, 250 MHz system clock
// Notes: configuration field positions sit in the low and high bits below
package adcsr_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
  localparam logic [3:0] MSB_IDX = 4'hf;
  // configuration word layout
  localparam int CFG_SS_BIT = 15;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_PULLUP_BIT = 3;
  localparam int CFG_WV_LSB = 1;
  localparam int CFG_WV_MSB = 2;
  localparam logic [1:0] WV_VALID = 2'h1;
  // continuous mode, pull-up on, write-valid 01, unused bit reads one
  localparam logic [WORD_W-1:0] CFG_RESET = 16'h000b;
  // sclk-low timeout
  localparam int TIMEOUT_MS = 28;
  localparam int SYS_CLK_KHZ = 250000;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * SYS_CLK_KHZ;
  localparam int FIFO_DEPTH = 4;
endpackage

// [rtl/adcsr_fifo.sv]
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: read data comes straight from the storage flops
`timescale 1ns/100ps
module adcsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } adcsr_fifo_state_type;
  adcsr_fifo_state_type st_ff, nxt_st;
  logic push, pop;

  assign inReady = st_ff.cnt != (AW+1)'(DEPTH);
  assign outValid = st_ff.cnt != '0;
  assign outData = st_ff.mem[st_ff.rp];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = inData;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  count_bound_a: assert property (@(posedge clk) disable iff (reset)
    st_ff.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count beyond its depth");
endmodule

// [rtl/adcsr_readout.sv]
// Purpose: serial readout of buffered conversion results, mode 1 slave
// Assumes: at least 4 sys_clk cycles between chip select falling and the
//   first sclk rising edge, and between frames
// Notes: pin logic is combinational on chip select so the ready level
//   appears at once; the pad resolves drive, enable and pull-up
`timescale 1ns/100ps
// What this block does
// - chip select high returns the link to idle, dropping partial frames.
// - next chip select low starts shifting the buffered result on first rise.
// - ready line low means fresh result follows; high means a repeat.
// - link runs as mode 1: polarity zero, phase one.
// - clock idles low; data change on rising and sampled on falling edges.
// - pull-up enabled by default holds the pin weakly high when deselected.
// - pull-up field cleared leaves the pin floating when deselected.
// - no ready indication is given while chip select is high.
// - chip select low drives the pin at once: low if unread, else high.
// - result completed mid-frame waits for a later frame.
// - result buffer always holds a whole, uncorrupted word.
// - bit 15 leaves on the first rise; input bits taken on falling edges.
// - mode 0 converts continuously; mode 1 waits for the start bit.
// - configuration changes only when the write-valid field is 01.
// - clock low for over 28 ms times the frame out.
module adcsr_readout
#(
  parameter int TIMEOUT_CYCLES = adcsr_pkg::TIMEOUT_CYC,
  parameter int DEPTH = adcsr_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic convValid,
  output logic convReady,
  input wire logic [adcsr_pkg::WORD_W-1:0] convData,
  output logic convStart,
  output logic convContinuous,
  output logic [adcsr_pkg::WORD_W-1:0] cfgWord,
  input wire logic sclk,
  input wire logic csN,
  input wire logic dataIn,
  output logic dataOutReadyN,
  output logic dataOutReadyOe,
  output logic dataOutPullUp
);
  import adcsr_pkg::*;
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  typedef struct packed {
    logic csS1, csS2;
    logic actS1, actS2, actS3;
    logic doneS1, doneS2, doneS3;
    logic [WORD_W-1:0] resultBuf;
    logic freshBuf;
    logic [WORD_W-1:0] txWord;
    logic newFlag;
    logic [WORD_W-1:0] cfg;
    logic convStart;
    logic [TW-1:0] toCnt;
    logic timeoutFlag;
  } adcsr_sys_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic started;
    logic txBit;
  } adcsr_rise_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] shift;
  } adcsr_fall_type;

  typedef struct packed {
    logic [WORD_W-1:0] rxWord;
    logic doneTgl;
  } adcsr_keep_type;

  localparam adcsr_sys_type SYS_RST = '{csS1: 1'b1, csS2: 1'b1,
    cfg: CFG_RESET, default: '0};

  adcsr_sys_type sys_ff, nxt_sys;
  adcsr_rise_type rise_ff, nxt_rise;
  adcsr_fall_type fall_ff, nxt_fall;
  adcsr_keep_type keep_ff, nxt_keep;
  logic actTgl_ff;
  logic linkRst;
  logic fifoValid, fifoReady;
  logic [WORD_W-1:0] fifoData;
  logic csActive, actEdge, doneEdge, pop, copy, cfgTake;

  adcsr_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .reset(reset),
    .inValid(convValid),
    .inReady(convReady),
    .inData(convData),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // frame state clears whenever the select is high or the frame timed out
  assign linkRst = csN | sys_ff.timeoutFlag;

  // ---------------- system domain ----------------
  assign csActive = !sys_ff.csS2;
  assign actEdge = sys_ff.actS2 ^ sys_ff.actS3;
  assign doneEdge = sys_ff.doneS2 ^ sys_ff.doneS3;
  // hold one fresh word back during a frame; the rest queue up
  assign fifoReady = !(csActive && sys_ff.freshBuf);
  assign pop = fifoValid & fifoReady;
  // shifter copy only changes while deselected, frozen through a frame
  assign copy = !csActive && sys_ff.freshBuf;
  assign cfgTake = doneEdge &&
    keep_ff.rxWord[CFG_WV_MSB:CFG_WV_LSB] == WV_VALID;

  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.csS1 = csN;
    nxt_sys.csS2 = sys_ff.csS1;
    nxt_sys.actS1 = actTgl_ff;
    nxt_sys.actS2 = sys_ff.actS1;
    nxt_sys.actS3 = sys_ff.actS2;
    nxt_sys.doneS1 = keep_ff.doneTgl;
    nxt_sys.doneS2 = sys_ff.doneS1;
    nxt_sys.doneS3 = sys_ff.doneS2;
    nxt_sys.convStart = 1'b0;
    if (doneEdge) begin
      nxt_sys.newFlag = 1'b0;
    end
    if (copy) begin
      nxt_sys.txWord = sys_ff.resultBuf;
      nxt_sys.newFlag = 1'b1;
      nxt_sys.freshBuf = 1'b0;
    end
    // whole words only; a new arrival wins over the copy clearing it
    if (pop) begin
      nxt_sys.resultBuf = fifoData;
      nxt_sys.freshBuf = 1'b1;
    end
    if (cfgTake) begin
      nxt_sys.cfg = keep_ff.rxWord;
      nxt_sys.cfg[CFG_SS_BIT] = 1'b0;
      nxt_sys.convStart = keep_ff.rxWord[CFG_SS_BIT] &
        keep_ff.rxWord[CFG_MODE_BIT];
    end
    if (!csActive || actEdge || sys_ff.timeoutFlag) begin
      nxt_sys.toCnt = '0;
    end else begin
      nxt_sys.toCnt = sys_ff.toCnt + 1'b1;
    end
    if (!csActive) begin
      nxt_sys.timeoutFlag = 1'b0;
    end else if (sys_ff.toCnt == TW'(TIMEOUT_CYCLES - 1)) begin
      nxt_sys.timeoutFlag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_ff <= SYS_RST;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign convStart = sys_ff.convStart;
  assign convContinuous = !sys_ff.cfg[CFG_MODE_BIT];
  assign cfgWord = sys_ff.cfg;

  // ---------------- link domain, rising edges ----------------
  always_comb begin
    nxt_rise = rise_ff;
    if (rise_ff.cnt != FRAME_BITS) begin
      nxt_rise.txBit = sys_ff.txWord[MSB_IDX - rise_ff.cnt[3:0]];
      nxt_rise.cnt = rise_ff.cnt + 1'b1;
      nxt_rise.started = 1'b1;
    end
  end

  // data change only on rising edges
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      rise_ff <= '0;
    end else begin
      rise_ff <= nxt_rise;
    end
  end

  // activity marker survives frames, so only system reset clears it
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      actTgl_ff <= 1'b0;
    end else begin
      actTgl_ff <= !actTgl_ff;
    end
  end

  // ---------------- link domain, falling edges ----------------
  always_comb begin
    nxt_fall = fall_ff;
    nxt_keep = keep_ff;
    if (fall_ff.cnt != FRAME_BITS) begin
      nxt_fall.shift = {fall_ff.shift[WORD_W-2:0], dataIn};
      nxt_fall.cnt = fall_ff.cnt + 1'b1;
    end
    // sixteenth falling edge: word complete and result fully shifted
    if (fall_ff.cnt == LAST_BIT) begin
      nxt_keep.rxWord = {fall_ff.shift[WORD_W-2:0], dataIn};
      nxt_keep.doneTgl = !keep_ff.doneTgl;
    end
  end

  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      fall_ff <= '0;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

  // received word stays stable until the next complete frame
  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      keep_ff <= '0;
    end else begin
      keep_ff <= nxt_keep;
    end
  end

  // ---------------- pin ----------------
  // before the first rise the pin shows the ready level
  assign dataOutReadyN = rise_ff.started ? rise_ff.txBit
                                         : !sys_ff.newFlag;
  assign dataOutReadyOe = !csN;
  assign dataOutPullUp = csN & sys_ff.cfg[CFG_PULLUP_BIT];

  // ---------------- assertions ----------------
  property p_done_clears;
    @(posedge sys_clk) disable iff (reset)
      doneEdge && !copy |=> !sys_ff.newFlag;
  endproperty
  done_clears_flag_a: assert property (p_done_clears)
    else $error("new flag survived a completed readout");

  flag_kept_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    $fell(sys_ff.newFlag) |-> $past(doneEdge))
    else $error("new flag dropped without a completed readout");

  copy_sets_flag_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    copy |=> sys_ff.newFlag && sys_ff.txWord == $past(sys_ff.resultBuf))
    else $error("shifter copy did not mark new data");

  frame_word_frozen_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    csActive && $past(csActive) |-> $stable(sys_ff.txWord))
    else $error("shifted word changed during a frame");

  stall_hold_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    csActive && sys_ff.freshBuf |=> $stable(sys_ff.resultBuf))
    else $error("held result replaced during a frame");

  pop_fills_buffer_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    pop |=> sys_ff.freshBuf && sys_ff.resultBuf == $past(fifoData))
    else $error("result buffer missed a completed conversion");

  invalid_cfg_kept_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    doneEdge && keep_ff.rxWord[CFG_WV_MSB:CFG_WV_LSB] != WV_VALID
      |=> $stable(sys_ff.cfg))
    else $error("configuration changed on invalid write code");

  start_only_single_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    $rose(sys_ff.convStart) |-> $past(cfgTake) &&
      $past(keep_ff.rxWord[CFG_MODE_BIT]) &&
      $past(keep_ff.rxWord[CFG_SS_BIT]))
    else $error("conversion start without single-shot request");

  start_single_mode_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    sys_ff.convStart |-> !convContinuous)
    else $error("single-shot start issued in continuous mode");

  timeout_fires_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    csActive && !actEdge && !sys_ff.timeoutFlag &&
      sys_ff.toCnt == TW'(TIMEOUT_CYCLES - 1) |=> sys_ff.timeoutFlag)
    else $error("sclk-low timeout missed");

  timeout_clears_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    sys_ff.timeoutFlag |-> !rise_ff.started && fall_ff.cnt == '0)
    else $error("timed-out frame kept its bit count");

  link_idle_reset_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    sys_ff.csS2 && $past(sys_ff.csS2) |-> rise_ff.cnt == '0 &&
      !rise_ff.started && fall_ff.cnt == '0)
    else $error("link frame state not cleared while deselected");

  msb_first_a: assert property (@(posedge sclk)
    disable iff (linkRst)
    rise_ff.cnt == 5'h01 |-> rise_ff.txBit == sys_ff.txWord[WORD_W-1])
    else $error("first bit out is not the result msb");

  // pin checks sample the raw select; it must move off the sys_clk edge
  deselect_pin_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    csN |-> !dataOutReadyOe)
    else $error("pin driven while deselected");

  pull_up_level_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    csN |-> dataOutPullUp == sys_ff.cfg[CFG_PULLUP_BIT])
    else $error("pull-up request disagrees with its enable");

  ready_level_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    !csN && !rise_ff.started |-> dataOutReadyOe &&
      dataOutReadyN == !sys_ff.newFlag)
    else $error("ready level wrong at chip select");

  full_frame_c: cover property (@(posedge sys_clk) disable iff (reset)
    doneEdge && sys_ff.newFlag);
  timeout_c: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(sys_ff.timeoutFlag));
  cfg_write_c: cover property (@(posedge sys_clk) disable iff (reset)
    cfgTake);
  stall_c: cover property (@(posedge sys_clk) disable iff (reset)
    !convReady);
  drain_c: cover property (@(posedge sys_clk) disable iff (reset)
    copy && pop);
endmodule

// [tb/adcsr_spi_master.sv]
// Purpose: mode 1 serial master driving the readout block's link side
// Assumes: link clock of 64 ns, started only inside frames
// Notes: data-in is inverted once released so stale bits never look valid
`timescale 1ns/100ps
module adcsr_spi_master (
  output logic sclk,
  output logic csN,
  output logic dataIn,
  input wire logic pad
);
  // select starts low so its first rise clears the link flops cleanly
  initial begin
    sclk = 1'b0;
    csN = 1'b0;
    dataIn = 1'b0;
    #3 csN = 1'b1;
  end

  task automatic frame(input logic [15:0] tx, input int nBits,
                       output logic [15:0] rx, output logic rdy);
    rx = 16'h0000;
    #1 csN = 1'b0;
    #8 rdy = pad;
    #24;
    for (int i = 0; i < nBits; i++) begin
      sclk = 1'b1;
      dataIn = tx[15-i];
      #32 sclk = 1'b0;
      rx = {rx[14:0], pad};
      #32;
    end
    dataIn = ~dataIn;
    csN = 1'b1;
    // room for a fresh word copy; frames keep a 1 ns offset from sys_clk
    #159;
  endtask

  // deliberately leaves sclk low past the block's timeout
  task automatic stall(input int nBits, input int waitNs,
                       output logic rdy);
    #1 csN = 1'b0;
    #32;
    for (int i = 0; i < nBits; i++) begin
      sclk = 1'b1;
      dataIn = 1'b1;
      #32 sclk = 1'b0;
      #32;
    end
    #(waitNs) rdy = pad;
    csN = 1'b1;
    #159;
  endtask
endmodule

// [tb/adcsr_readout_test.sv]
// Purpose: self-checking bench for the serial result readout block
// Assumes: timeout parameter shortened to 200 system cycles
// Notes: pad level resolved here from drive, enable and pull-up
`timescale 1ns/100ps
module adcsr_readout_test;
  import adcsr_pkg::*;
  logic sysClk = 1'b0;
  logic reset = 1'b0;
  logic convValid = 1'b0;
  logic [15:0] convData = 16'h0000;
  logic convReady, convStart, convContinuous;
  logic [15:0] cfgWord;
  logic sclk, csN, dataIn, dataOutReadyN, dataOutReadyOe, dataOutPullUp;
  wire pad;
  int errCount = 0;
  int checkCount = 0;
  int cycles = 0;
  int startCount = 0;
  logic [31:0] seed = 32'hed0fad68;
  logic [15:0] rx, last, cur;
  logic rdy;

  assign pad = dataOutReadyOe ? dataOutReadyN :
               (dataOutPullUp ? 1'b1 : 1'bz);
  always #2 sysClk = ~sysClk;

  adcsr_readout #(.TIMEOUT_CYCLES(200), .DEPTH(4)) dut (
    .sys_clk(sysClk), .reset(reset), .convValid(convValid),
    .convReady(convReady), .convData(convData), .convStart(convStart),
    .convContinuous(convContinuous), .cfgWord(cfgWord), .sclk(sclk),
    .csN(csN), .dataIn(dataIn), .dataOutReadyN(dataOutReadyN),
    .dataOutReadyOe(dataOutReadyOe), .dataOutPullUp(dataOutPullUp));

  adcsr_spi_master master (.sclk(sclk), .csN(csN), .dataIn(dataIn),
    .pad(pad));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // only write-valid 01 replaces the word; start bit never reads back
  function automatic logic [15:0] expCfg(input logic [15:0] old,
                                         input logic [15:0] tx);
    return (tx[2:1] == WV_VALID) ? {1'b0, tx[14:0]} : old;
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic push(input logic [15:0] d);
    @(posedge sysClk);
    #1 convValid = 1'b1;
    convData = d;
    @(posedge sysClk);
    #1 convValid = 1'b0;
  endtask

  function automatic logic [15:0] nextWord();
    seed = lfsr(seed);
    return seed[15:0];
  endfunction

  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (convStart === 1'b1)
      startCount <= startCount + 1;
    if (cycles == 20000) begin
      errCount++;
      summarize();
    end
  end

  initial begin
    // raised after time zero so every asynchronous reset sees an edge
    #1 reset = 1'b1;
    repeat (4) @(posedge sysClk);
    #1 reset = 1'b0;
    repeat (8) @(posedge sysClk);
    chk("cfg", CFG_RESET, cfgWord);
    chk("cont", 16'h0001, {15'h0, convContinuous});
    chk("pull", 16'h0001, {15'h0, dataOutPullUp});
    chk("oe", 16'h0000, {15'h0, dataOutReadyOe});
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      last = (k == 0) ? 16'hffff : nextWord();
      push(last);
      repeat (10) @(posedge sysClk);
      master.frame(CFG_RESET, 16, rx, rdy);
      chk("rdyNew", 16'h0000, {15'h0, rdy});
      chk("rxNew", last, rx);
      master.frame(CFG_RESET, 16, rx, rdy);
      chk("rdyOld", 16'h0001, {15'h0, rdy});
      chk("rxOld", last, rx);
    end
    $display("test readout done");
    last = nextWord();
    push(last);
    repeat (10) @(posedge sysClk);
    master.frame(CFG_RESET, 7, rx, rdy);
    master.frame(CFG_RESET, 16, rx, rdy);
    chk("rdyPart", 16'h0000, {15'h0, rdy});
    chk("rxPart", last, rx);
    $display("test partial done");
    last = 16'hffff;
    push(last);
    repeat (10) @(posedge sysClk);
    master.stall(3, 1200, rdy);
    chk("stallRdy", 16'h0000, {15'h0, rdy});
    master.frame(CFG_RESET, 16, rx, rdy);
    chk("rdyStall", 16'h0000, {15'h0, rdy});
    chk("rxStall", last, rx);
    $display("test timeout done");
    cur = last;
    fork
      master.frame(CFG_RESET, 16, rx, rdy);
      begin
        #100;
        for (int i = 0; i < 5; i++) begin
          last = nextWord();
          push(last);
        end
        #2 chk("full", 16'h0000, {15'h0, convReady});
      end
    join
    chk("rxMid", cur, rx);
    master.frame(CFG_RESET, 16, rx, rdy);
    chk("rdyMid", 16'h0000, {15'h0, rdy});
    chk("rxLate", last, rx);
    chk("drain", 16'h0001, {15'h0, convReady});
    $display("test midframe done");
    cur = CFG_RESET;
    for (int w = 0; w < 4; w++) begin
      last = {13'h0, 2'(3 - w), 1'b1};
      master.frame(last, 16, rx, rdy);
      cur = expCfg(cur, last);
      chk("cfgWv", cur, cfgWord);
    end
    chk("pullOff", 16'h0000, {15'h0, dataOutPullUp});
    chk("float", 16'h0000, {15'h0, (pad === 1'bz) ? 1'b0 : 1'b1});
    master.frame(16'h8103, 16, rx, rdy);
    chk("single", 16'h0000, {15'h0, convContinuous});
    chk("start", 16'h0001, 16'(startCount));
    master.frame(CFG_RESET, 16, rx, rdy);
    chk("contBack", 16'h0001, {15'h0, convContinuous});
    chk("padUp", 16'h0001, {15'h0, pad});
    $display("test config done");
    summarize();
  end
endmodule
